// *** src/led_dim_update_interval.v ***
`timescale 1ns/1ps

`include "led_dim_map.vh"

module led_dim_update_interval #(
  parameter DUTY_W = 12,
  parameter PERIOD_LEN_0 = `PERIOD_LEN_DEFAULT,
  parameter PERIOD_LEN_1 = `PERIOD_LEN_1,
  parameter PERIOD_LEN_2 = `PERIOD_LEN_2,
  parameter PERIOD_LEN_3 = `PERIOD_LEN_3,
  parameter CNT_W = 13
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,

  // Register access
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output wire [15:0] reg_rdata_o,
  output wire reg_rvalid_o,

  // Duty requests
  input wire ch7_duty_wr_i,
  input wire [DUTY_W-1:0] ch7_duty_i,
  input wire ch8_duty_wr_i,
  input wire [DUTY_W-1:0] ch8_duty_i,
  input wire ch9_duty_wr_i,
  input wire [DUTY_W-1:0] ch9_duty_i,

  // Applied duty and update strobes
  output wire [DUTY_W-1:0] ch7_duty_o,
  output wire [DUTY_W-1:0] ch8_duty_o,
  output wire [DUTY_W-1:0] ch9_duty_o,
  output wire ch7_update_o,
  output wire ch8_update_o,
  output wire ch9_update_o,
  output wire [2:0] duty_pending_o,

  // Period timing
  output wire [CNT_W-1:0] period_cnt_o,
  output wire period_end_o
);

  // Period length for a setting, as last count value
  function [CNT_W-1:0] period_last;
    input [1:0] psel;
    begin
      case (psel)
        2'h0: period_last = PERIOD_LEN_0[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        2'h1: period_last = PERIOD_LEN_1[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        2'h2: period_last = PERIOD_LEN_2[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        2'h3: period_last = PERIOD_LEN_3[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        default: period_last = PERIOD_LEN_0[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
      endcase
    end
  endfunction

  // Register storage
  reg [`SEL_W-1:0] ch7_update_interval_sel_ff;
  reg [`SEL_W-1:0] ch8_update_interval_sel_ff;
  reg [`SEL_W-1:0] ch9_update_interval_sel_ff;
  reg [`PERIOD_SEL_W-1:0] period_sel_ff;

  // Read port
  reg [15:0] rdata_ff;
  reg rvalid_ff;
  reg [15:0] nxt_rdata;

  // Period counter
  reg [CNT_W-1:0] period_cnt_ff;
  reg period_end_ff;
  wire [CNT_W-1:0] cur_period_last;
  wire period_wrap;

  // Assembled selector register
  wire [`DIM_INTERVAL_W-1:0] led9_to_7_dim_update_interval;

  // Write decode
  wire wr_interval;
  wire wr_cfg;

  assign wr_interval = reg_wr_i && (reg_addr_i == `ADDR_DIM_INTERVAL);
  assign wr_cfg = reg_wr_i && (reg_addr_i == `ADDR_PWM_CFG);

  // Selector and period-field storage; unused bits are dropped
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch7_update_interval_sel_ff <= `SEL_RST;
      ch8_update_interval_sel_ff <= `SEL_RST;
      ch9_update_interval_sel_ff <= `SEL_RST;
      period_sel_ff <= `PERIOD_SEL_RST;
    end else begin
      if (wr_interval) begin
        ch7_update_interval_sel_ff <= reg_wdata_i[`CH7_SEL_LSB +: `SEL_W];
        ch8_update_interval_sel_ff <= reg_wdata_i[`CH8_SEL_LSB +: `SEL_W];
        ch9_update_interval_sel_ff <= reg_wdata_i[`CH9_SEL_LSB +: `SEL_W];
      end
      if (wr_cfg) begin
        period_sel_ff <= reg_wdata_i[`PERIOD_SEL_LSB +: `PERIOD_SEL_W];
      end
    end
  end

  // Reserved bits 3 and 7 read as zero
  assign led9_to_7_dim_update_interval = {
    ch9_update_interval_sel_ff, 1'b0,
    ch8_update_interval_sel_ff, 1'b0,
    ch7_update_interval_sel_ff
  };

  // Read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = 16'h0000;
    case (reg_addr_i)
      `ADDR_DIM_INTERVAL: begin
        nxt_rdata[`DIM_INTERVAL_W-1:0] = led9_to_7_dim_update_interval;
      end
      `ADDR_PWM_CFG: begin
        nxt_rdata[`PERIOD_SEL_LSB +: `PERIOD_SEL_W] = period_sel_ff;
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

  // Period length tracks the configuration field live
  assign cur_period_last = period_last(period_sel_ff);
  // Compare with >= so a shorter setting ends an overlong period at once
  assign period_wrap = (period_cnt_ff >= cur_period_last);

  // Free-running PWM period counter shared by all three channels
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_cnt_ff <= {CNT_W{1'b0}};
      period_end_ff <= 1'b0;
    end else begin
      period_end_ff <= period_wrap;
      if (period_wrap) begin
        period_cnt_ff <= {CNT_W{1'b0}};
      end else begin
        period_cnt_ff <= period_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign period_cnt_o = period_cnt_ff;
  assign period_end_o = period_wrap;

  // Channel 7 interval logic
  dim_interval_counter #(
    .DUTY_W(DUTY_W)
  ) u_ch7 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .period_end_i(period_wrap),
    .interval_sel_i(ch7_update_interval_sel_ff),
    .duty_wr_i(ch7_duty_wr_i),
    .duty_i(ch7_duty_i),
    .duty_o(ch7_duty_o),
    .update_o(ch7_update_o),
    .pending_o(duty_pending_o[0])
  );

  // Channel 8 interval logic
  dim_interval_counter #(
    .DUTY_W(DUTY_W)
  ) u_ch8 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .period_end_i(period_wrap),
    .interval_sel_i(ch8_update_interval_sel_ff),
    .duty_wr_i(ch8_duty_wr_i),
    .duty_i(ch8_duty_i),
    .duty_o(ch8_duty_o),
    .update_o(ch8_update_o),
    .pending_o(duty_pending_o[1])
  );

  // Channel 9 interval logic
  dim_interval_counter #(
    .DUTY_W(DUTY_W)
  ) u_ch9 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .period_end_i(period_wrap),
    .interval_sel_i(ch9_update_interval_sel_ff),
    .duty_wr_i(ch9_duty_wr_i),
    .duty_i(ch9_duty_i),
    .duty_o(ch9_duty_o),
    .update_o(ch9_update_o),
    .pending_o(duty_pending_o[2])
  );

endmodule // led_dim_update_interval

// *** src/led_dim_map.vh ***
`ifndef LED_DIM_MAP_VH
`define LED_DIM_MAP_VH

// Register addresses
`define ADDR_PWM_CFG 8'h02
`define ADDR_DIM_INTERVAL 8'h33

// Update-interval register layout, one selector per channel
`define CH7_SEL_LSB 0
`define CH8_SEL_LSB 4
`define CH9_SEL_LSB 8
`define SEL_W 3
`define DIM_INTERVAL_W 11
`define DIM_INTERVAL_RST 11'h000
`define SEL_RST 3'h0

// Period-length field of the configuration register
`define PERIOD_SEL_LSB 2
`define PERIOD_SEL_W 2
`define PERIOD_SEL_RST 2'h0

// Selector decode: longest interval is 32 periods, codes above 5 clamp
`define SEL_MAX_CODE 3'h5
`define INTERVAL_MAX_LAST 5'h1f

// PWM period lengths in dimming-clock cycles
`define PERIOD_LEN_DEFAULT 8192
`define PERIOD_LEN_1 4096
`define PERIOD_LEN_2 2048
`define PERIOD_LEN_3 1024

`endif

// *** src/dim_interval_counter.v ***
`timescale 1ns/1ps

// Per-channel update-interval counter and duty shadow
module dim_interval_counter #(
  parameter DUTY_W = 12
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Period timing
  input wire period_end_i,
  input wire [2:0] interval_sel_i,
  // Duty request
  input wire duty_wr_i,
  input wire [DUTY_W-1:0] duty_i,
  // Applied duty
  output wire [DUTY_W-1:0] duty_o,
  output wire update_o,
  output wire pending_o
);

`include "led_dim_map.vh"

  // Last count of the interval; codes 6 and 7 behave as code 5
  function [4:0] interval_last;
    input [2:0] sel;
    begin
      if (sel >= `SEL_MAX_CODE) begin
        interval_last = `INTERVAL_MAX_LAST;
      end else begin
        interval_last = (5'h01 << sel) - 5'h01;
      end
    end
  endfunction

  reg [4:0] period_cnt_ff;
  reg [DUTY_W-1:0] shadow_ff;
  reg [DUTY_W-1:0] duty_ff;
  reg pending_ff;
  reg update_ff;
  wire interval_done;
  wire [DUTY_W-1:0] nxt_shadow;

  // Compare with >= so a shortened selector closes the interval at the next period end
  assign interval_done = period_end_i && (period_cnt_ff >= interval_last(interval_sel_i));
  // A write in the apply cycle is taken, not lost
  assign nxt_shadow = duty_wr_i ? duty_i : shadow_ff;

  // Count whole periods and apply the shadow only at an interval end
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_cnt_ff <= 5'h00;
      shadow_ff <= {DUTY_W{1'b0}};
      duty_ff <= {DUTY_W{1'b0}};
      pending_ff <= 1'b0;
      update_ff <= 1'b0;
    end else begin
      shadow_ff <= nxt_shadow;
      update_ff <= interval_done;
      if (interval_done) begin
        period_cnt_ff <= 5'h00;
        duty_ff <= nxt_shadow;
        pending_ff <= 1'b0;
      end else begin
        if (period_end_i) begin
          period_cnt_ff <= period_cnt_ff + 5'h01;
        end
        if (duty_wr_i) begin
          pending_ff <= 1'b1;
        end
      end
    end
  end

  assign duty_o = duty_ff;
  assign update_o = update_ff;
  assign pending_o = pending_ff;

endmodule // dim_interval_counter

// *** testbench/dim_sva.sv ***
`timescale 1ns/1ps
module dim_sva #(parameter DUTY_W = 12, parameter CNT_W = 13) (
  // Clock, reset and read handshake
  input wire sys_clk_i,
  input wire rst_i,
  input wire reg_rd_i,
  input wire reg_rvalid_o,
  // Channel 7 and period timing
  input wire ch7_duty_wr_i,
  input wire [DUTY_W-1:0] ch7_duty_o,
  input wire ch7_update_o,
  input wire [2:0] duty_pending_o,
  input wire [CNT_W-1:0] period_cnt_o,
  input wire period_end_o
);
  // Reset masks every check
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Read request then its answer
  sequence s_read;
    reg_rd_i ##1 reg_rvalid_o;
  endsequence
  a_read_answer: assert property (reg_rd_i |-> s_read)
    else $error("read unanswered");
  a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray read valid");
  a_period_wrap: assert property (period_end_o |=> period_cnt_o == 0)
    else $error("period did not wrap");
  a_count_step: assert property (!period_end_o |=> period_cnt_o == $past(period_cnt_o) + 1'b1)
    else $error("period count skipped");
  a_update_cause: assert property (ch7_update_o |-> $past(period_end_o))
    else $error("update off period end");
  a_duty_hold: assert property (!period_end_o |=> $stable(ch7_duty_o))
    else $error("duty changed mid period");
  a_pending_set: assert property (ch7_duty_wr_i && !period_end_o |=> duty_pending_o[0])
    else $error("write not pending");
  a_pending_clear: assert property (ch7_update_o |-> !duty_pending_o[0])
    else $error("pending after apply");
  a_update_pulse: assert property (ch7_update_o |=> !ch7_update_o)
    else $error("update held");
endmodule // dim_sva
bind led_dim_update_interval dim_sva #(.DUTY_W(DUTY_W), .CNT_W(CNT_W)) u_sva (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
  .ch7_duty_wr_i(ch7_duty_wr_i), .ch7_duty_o(ch7_duty_o), .ch7_update_o(ch7_update_o),
  .duty_pending_o(duty_pending_o), .period_cnt_o(period_cnt_o), .period_end_o(period_end_o));

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "led_dim_map.vh"
module tb_top;
  localparam int PL[4] = '{16, 8, 4, 2};
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] adr = 0;
  logic [15:0] wd = 0;
  logic [15:0] v = 0;
  logic [2:0] dwr = 0;
  logic [11:0] dv = 0;
  wire [15:0] rdat;
  wire rval, pend_end;
  wire [11:0] d7, d8, d9;
  wire [2:0] upd, pend;
  wire [12:0] cnt;
  int failures = 0, checks_done = 0, seed = 40860, cyc = 0, k = 0, ne = 0, nc = 0, pc = 0;
  logic [15:0] rq[$];
  logic [31:0] dq[$];
  logic [31:0] pq[$];
  logic [31:0] ap;
  wire dflt_end;
  wire [11:0] ds = k == 0 ? d7 : (k == 1 ? d8 : d9);

  always #4 sys_clk_i = ~sys_clk_i;

  // Short periods keep the run small
  led_dim_update_interval #(.PERIOD_LEN_0(16), .PERIOD_LEN_1(8), .PERIOD_LEN_2(4),
    .PERIOD_LEN_3(2)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(adr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rval),
    .ch7_duty_wr_i(dwr[0]), .ch7_duty_i(dv), .ch8_duty_wr_i(dwr[1]), .ch8_duty_i(dv),
    .ch9_duty_wr_i(dwr[2]), .ch9_duty_i(dv), .ch7_duty_o(d7), .ch8_duty_o(d8),
    .ch9_duty_o(d9), .ch7_update_o(upd[0]), .ch8_update_o(upd[1]), .ch9_update_o(upd[2]),
    .duty_pending_o(pend), .period_cnt_o(cnt), .period_end_o(pend_end));

  // Default period length needs its own instance, the main one runs short periods
  led_dim_update_interval dflt (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(8'h00),
    .reg_wr_i(1'b0), .reg_rd_i(1'b0), .reg_wdata_i(16'h0000), .reg_rdata_o(), .reg_rvalid_o(),
    .ch7_duty_wr_i(1'b0), .ch7_duty_i(12'h000), .ch8_duty_wr_i(1'b0), .ch8_duty_i(12'h000),
    .ch9_duty_wr_i(1'b0), .ch9_duty_i(12'h000), .ch7_duty_o(), .ch8_duty_o(), .ch9_duty_o(),
    .ch7_update_o(), .ch8_update_o(), .ch9_update_o(), .duty_pending_o(), .period_cnt_o(),
    .period_end_o(dflt_end));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bus cycles, one strobe cycle each; a write idles one cycle so strobes never glitch
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    adr = a;
    wd = d;
    wr = 1;
    @(posedge sys_clk_i) #1 wr = 0;
    @(posedge sys_clk_i) #1;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    adr = a;
    rd = 1;
    @(posedge sys_clk_i) #1 rd = 0;
    @(posedge sys_clk_i) #1;
  endtask

  // Watcher: cycles and period ends between updates of the watched channel
  // Pending must read clear in the cycle the update strobe stands
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end else begin
      if (rval === 1'b1 && rq.size() > 0) chk("rdata", rdat, rq.pop_front());
      nc++;
      if (pend_end === 1'b1) ne++;
      if (upd[k] === 1'b1) begin
        ap = {ds, 6'(ne), 13'(nc), pend[k]};
        if (dq.size() > 0) chk("apply", ap, dq.pop_front());
        ne = 0;
        nc = 0;
      end
      // Cycles per period on the default-length instance
      if (rst_i === 1'b0) pc++;
      if (dflt_end === 1'b1) begin
        if (pq.size() > 0) chk("default period", pc, pq.pop_front());
        pc = 0;
      end
    end
  end

  initial begin
    int i, n;
    repeat (2) pq.push_back(32'h2000);
    repeat (6) @(posedge sys_clk_i);
    #1 rst_i = 0;
    rreg(`ADDR_DIM_INTERVAL, 16'h0000);
    rreg(`ADDR_PWM_CFG, 16'h0000);
    $display("reset values done");
    v = 16'($random(seed));
    wreg(`ADDR_DIM_INTERVAL, v);
    wreg(8'h34, 16'hffff);
    rreg(`ADDR_DIM_INTERVAL, v & 16'h0777);
    rreg(8'h34, 16'h0000);
    $display("register map done");
    // Every period setting, channel and selector code
    for (int p = 0; p < 4; p++) begin
      for (k = 0; k < 3; k++) begin
        for (int c = 0; c < 8; c++) begin
          wreg(`ADDR_PWM_CFG, (v & 16'hfff3) | 16'(p << 2));
          wreg(`ADDR_DIM_INTERVAL, 16'(c << (4 * k)));
          for (i = 0; i < 700 && upd[k] !== 1'b1; i++) @(posedge sys_clk_i) #1;
          @(posedge sys_clk_i) #1;
          dv = 12'($random(seed));
          n = 1 << (c > 5 ? 5 : c);
          dq.push_back({dv, 6'(n), 13'(n * PL[p]), 1'b0});
          dwr[k] = 1;
          @(posedge sys_clk_i) #1 dwr = 0;
          for (i = 0; i < 700 && dq.size() > 0; i++) @(posedge sys_clk_i) #1;
        end
      end
    end
    chk("left", dq.size(), 0);
    chk("queues left", rq.size() + pq.size(), 0);
    $display("interval sweep done");
    results();
  end
endmodule // tb_top
